// file: rtl/timer_channel_irq_status.sv
// five-channel interrupt-enable and status-flag logic of the timer
// Notes on behaviour
// - enable bit 2 gates source C, channels 0,3,4
// - channels 1,2 enable bit 2 reads 0
// - enable bit 1 gates source B request
// - enable bit 0 gates source A request
// - status bit 7 shows count direction, resets 1
// - channel 0 status bit 7 reads 1
// - status bit 6 always reads 1
// - phase-mode wrap down sets underflow, channels 1,2
// - channels 0,3,4 status bit 5 reads 0
// - underflow cleared by 0 after reading 1
// - wrap up sets overflow flag, every channel
// - channel 4 complementary PWM 1-to-0 sets overflow
// - overflow cleared by 0 after reading 1
// - channel 4 transfer start clears overflow unless transfer disable select is set
// - enable bit 4 gates overflow request
// - enable bit 5 gates underflow, channels 1,2
//
// The APB register port and the address map were decided locally.
module timer_channel_irq_status (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  timer_link_if.device_end        link,
  input  wire logic [4:0]         source_a_event_i,
  input  wire logic [4:0]         source_b_event_i,
  input  wire logic [4:0]         source_c_event_i,
  input  wire logic [4:0]         wrap_up_i,
  input  wire logic [4:0]         wrap_down_i,
  input  wire logic [4:0]         phase_mode_i,
  input  wire logic [4:0]         count_up_i,
  input  wire logic               comp_pwm_i,
  input  wire logic               ch4_down_to_zero_i
);
  localparam int N = timer_irq_pkg::CH_COUNT;

  logic [7:0] enable_view [N];
  logic [7:0] status_view [N];
  logic [7:0] acc_rdata;
  logic [7:0] next_acc_rdata;
  logic       acc_done;
  logic       next_acc_done;

  genvar c;
  generate
    for (c = 0; c < N; c = c + 1) begin : g_ch
      // writable enable bits depend on which sources the channel has
      localparam logic HAS_C   = timer_irq_pkg::has_src_c(c);
      localparam logic HAS_UDF = timer_irq_pkg::has_udf(c);
      localparam logic [7:0] WMASK = (8'h01 << timer_irq_pkg::BIT_SRC_A)
                                   | (8'h01 << timer_irq_pkg::BIT_SRC_B)
                                   | (8'h01 << timer_irq_pkg::BIT_OVF)
                                   | (HAS_C ? (8'h01 << timer_irq_pkg::BIT_SRC_C) : 8'h00)
                                   | (HAS_UDF ? (8'h01 << timer_irq_pkg::BIT_UDF) : 8'h00);

      logic [7:0] enable;
      logic [7:0] next_enable;
      logic       dir;
      logic       next_dir;
      logic       hit;
      logic       st_read;
      logic       st_write;
      logic       flag_a;
      logic       flag_b;
      logic       flag_c;
      logic       flag_ovf;
      logic       flag_udf;
      logic       set_ovf;
      logic       set_udf;
      logic       clr_ovf;

      assign hit      = link.acc_valid && (link.acc_ch == 3'(c));
      assign st_read  = hit && !link.acc_write && link.acc_status_sel;
      assign st_write = hit && link.acc_write && link.acc_status_sel;

      always_comb begin
        next_enable = enable;
        if (hit && link.acc_write && !link.acc_status_sel) begin
          next_enable = (link.acc_wdata & WMASK) | timer_irq_pkg::ENABLE_RESET;
        end
        // counter direction has no meaning in channel 0
        next_dir = (c == 0) ? 1'b1 : count_up_i[c];
      end

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          enable <= timer_irq_pkg::ENABLE_RESET;
          dir    <= timer_irq_pkg::DIR_RESET;
        end else begin
          enable <= next_enable;
          dir    <= next_dir;
        end
      end

      assign set_ovf = wrap_up_i[c]
                     || ((c == 4) && comp_pwm_i && ch4_down_to_zero_i);
      assign set_udf = HAS_UDF && phase_mode_i[c] && wrap_down_i[c];
      // only the channel tied to the transfer controller sees its start
      assign clr_ovf = (c == timer_irq_pkg::DTC_CH) && link.dtc_ovf_start
                     && !link.transfer_disable_select;

      status_flag_cell u_flag_a (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (source_a_event_i[c]),
        .read_i     (st_read),
        .write_i    (st_write),
        .wbit_i     (link.acc_wdata[timer_irq_pkg::BIT_SRC_A]),
        .hw_clear_i (1'b0),
        .flag_o     (flag_a)
      );

      status_flag_cell u_flag_b (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (source_b_event_i[c]),
        .read_i     (st_read),
        .write_i    (st_write),
        .wbit_i     (link.acc_wdata[timer_irq_pkg::BIT_SRC_B]),
        .hw_clear_i (1'b0),
        .flag_o     (flag_b)
      );

      status_flag_cell u_flag_c (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (HAS_C && source_c_event_i[c]),
        .read_i     (st_read),
        .write_i    (st_write),
        .wbit_i     (link.acc_wdata[timer_irq_pkg::BIT_SRC_C]),
        .hw_clear_i (1'b0),
        .flag_o     (flag_c)
      );

      status_flag_cell u_flag_ovf (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (set_ovf),
        .read_i     (st_read),
        .write_i    (st_write),
        .wbit_i     (link.acc_wdata[timer_irq_pkg::BIT_OVF]),
        .hw_clear_i (clr_ovf),
        .flag_o     (flag_ovf)
      );

      status_flag_cell u_flag_udf (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .set_i      (set_udf),
        .read_i     (st_read),
        .write_i    (st_write),
        .wbit_i     (link.acc_wdata[timer_irq_pkg::BIT_UDF]),
        .hw_clear_i (1'b0),
        .flag_o     (flag_udf)
      );

      // reserved status bits are forced, not stored, so writes cannot disturb them; reserved enable bits are stored, mask clears them, ENABLE_RESET sets bit 6
      assign enable_view[c] = enable;
      assign status_view[c] = {dir,
                               1'b1,
                               flag_udf && HAS_UDF,
                               flag_ovf,
                               1'b0,
                               flag_c && HAS_C,
                               flag_b,
                               flag_a};

      assign link.source_a_irq[c]  = flag_a && enable[timer_irq_pkg::BIT_SRC_A];
      assign link.source_b_irq[c]  = flag_b && enable[timer_irq_pkg::BIT_SRC_B];
      assign link.source_c_irq[c]  = flag_c && enable[timer_irq_pkg::BIT_SRC_C];
      assign link.overflow_irq[c]  = flag_ovf && enable[timer_irq_pkg::BIT_OVF];
      assign link.underflow_irq[c] = flag_udf && enable[timer_irq_pkg::BIT_UDF];
    end
  endgenerate

  // access answers one cycle later; read data shows the pre-access state
  always_comb begin
    next_acc_rdata = acc_rdata;
    next_acc_done  = link.acc_valid;
    if (link.acc_valid && !link.acc_write) begin
      if (link.acc_ch < 3'(N)) begin
        next_acc_rdata = link.acc_status_sel ? status_view[link.acc_ch]
                                             : enable_view[link.acc_ch];
      end else begin
        next_acc_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_rdata <= 8'h00;
      acc_done  <= 1'b0;
    end else begin
      acc_rdata <= next_acc_rdata;
      acc_done  <= next_acc_done;
    end
  end

  assign link.acc_rdata = acc_rdata;
  assign link.acc_done  = acc_done;
endmodule

// file: rtl/timer_irq_pkg.sv
// shared constants and helpers for the timer interrupt-enable/status block
package timer_irq_pkg;
  localparam int          CH_COUNT      = 5;
  localparam int          BIT_SRC_A     = 0;
  localparam int          BIT_SRC_B     = 1;
  localparam int          BIT_SRC_C     = 2;
  localparam int          BIT_OVF       = 4;
  localparam int          BIT_UDF       = 5;
  localparam int          BIT_ONE6      = 6;
  localparam int          BIT_DIR       = 7;
  localparam logic [7:0]  ENABLE_RESET  = 8'h40;
  localparam logic [7:0]  STATUS_RESET  = 8'hC0;
  localparam logic        DIR_RESET     = 1'h1;
  // controller register map (byte addresses, one word each)
  localparam logic [11:0] OFF_CMD       = 12'h000;
  localparam logic [11:0] OFF_RESULT    = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h00C;
  localparam logic [11:0] OFF_XFER_CTRL = 12'h010;
  localparam int          CMD_CH_LSB    = 8;
  localparam int          CMD_SEL_BIT   = 12;
  localparam int          CMD_WR_BIT    = 16;
  localparam int          RES_BUSY_BIT  = 8;
  localparam int          IRQ_SRC_A     = 0;
  localparam int          IRQ_SRC_B     = 1;
  localparam int          IRQ_SRC_C     = 2;
  localparam int          IRQ_OVF       = 3;
  localparam int          IRQ_UDF       = 4;
  localparam int          IRQ_DONE      = 5;
  localparam int          IRQ_WIDTH     = 6;
  localparam int          XFER_EN_BIT   = 0;
  localparam int          XFER_DIS_BIT  = 1;
  localparam int          DTC_CH        = 4;

  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_ISSUE = 2'b01,
    ACC_WAIT  = 2'b10
  } access_state_type;

  function automatic logic has_src_c(input int ch);
    return (ch == 0) || (ch == 3) || (ch == 4);
  endfunction

  function automatic logic has_udf(input int ch);
    return (ch == 1) || (ch == 2);
  endfunction
endpackage

// file: rtl/timer_link_if.sv
// link between the timer channel block and its interrupt/transfer controller
interface timer_link_if;
  logic       acc_valid;
  logic       acc_write;
  logic       acc_status_sel;
  logic [2:0] acc_ch;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic       acc_done;
  logic [4:0] source_a_irq;
  logic [4:0] source_b_irq;
  logic [4:0] source_c_irq;
  logic [4:0] overflow_irq;
  logic [4:0] underflow_irq;
  logic       dtc_ovf_start;
  logic       transfer_disable_select;

  modport device_end (
    input  acc_valid, acc_write, acc_status_sel, acc_ch, acc_wdata,
    input  dtc_ovf_start, transfer_disable_select,
    output acc_rdata, acc_done,
    output source_a_irq, source_b_irq, source_c_irq, overflow_irq, underflow_irq
  );

  modport controller_end (
    output acc_valid, acc_write, acc_status_sel, acc_ch, acc_wdata,
    output dtc_ovf_start, transfer_disable_select,
    input  acc_rdata, acc_done,
    input  source_a_irq, source_b_irq, source_c_irq, overflow_irq, underflow_irq
  );
endinterface

// file: rtl/status_flag_cell.sv
// one status flag: hardware set, cleared by writing 0 after reading 1
module status_flag_cell (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic read_i,
  input  wire logic write_i,
  input  wire logic wbit_i,
  input  wire logic hw_clear_i,
  output logic      flag_o
);
  logic flag;
  logic armed;
  logic next_flag;
  logic next_armed;

  always_comb begin
    next_flag  = flag;
    next_armed = armed;
    if (read_i && flag) begin
      next_armed = 1'b1;
    end
    // a write of 1, or a 0 without a prior read of 1, leaves the flag alone
    if ((write_i && !wbit_i && armed) || hw_clear_i) begin
      next_flag  = 1'b0;
      next_armed = 1'b0;
    end
    // an event in the clearing cycle is kept
    if (set_i) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag  <= 1'b0;
      armed <= 1'b0;
    end else begin
      flag  <= next_flag;
      armed <= next_armed;
    end
  end

  assign flag_o = flag;
endmodule

// file: rtl/timer_irq_controller.sv
// interrupt/transfer controller end: APB registers driving the timer link
module timer_irq_controller (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [11:0]        paddr_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [31:0]        pwdata_i,
  output logic      [31:0]        prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  output logic                    irq_o,
  timer_link_if.controller_end    link
);
  localparam int W = timer_irq_pkg::IRQ_WIDTH;

  timer_irq_pkg::access_state_type state;
  timer_irq_pkg::access_state_type next_state;

  logic [7:0]  cmd_data, next_cmd_data;
  logic [2:0]  cmd_ch, next_cmd_ch;
  logic        cmd_sel, next_cmd_sel;
  logic        cmd_wr, next_cmd_wr;
  logic [7:0]  result, next_result;
  logic [W-1:0] irq_stat, next_irq_stat;
  logic [W-1:0] irq_mask, next_irq_mask;
  logic [W-1:0] events;
  logic [4:0]  any_prev, next_any_prev;
  logic [4:0]  any_now;
  logic        xfer_en, next_xfer_en;
  logic        xfer_dis, next_xfer_dis;
  logic        dtc_start, next_dtc_start;
  logic        dtc_wait, next_dtc_wait;
  logic [31:0] rdata, next_rdata;
  logic        wr_acc;

  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign any_now = {|link.underflow_irq, |link.overflow_irq, |link.source_c_irq,
                    |link.source_b_irq, |link.source_a_irq};
  // a request group counts as an event when it first rises
  assign events = {link.acc_done && (state == timer_irq_pkg::ACC_WAIT),
                   any_now & ~any_prev};

  always_comb begin
    next_state     = state;
    next_cmd_data  = cmd_data;
    next_cmd_ch    = cmd_ch;
    next_cmd_sel   = cmd_sel;
    next_cmd_wr    = cmd_wr;
    next_result    = result;
    next_irq_mask  = irq_mask;
    next_xfer_en   = xfer_en;
    next_xfer_dis  = xfer_dis;
    next_any_prev  = any_now;
    next_irq_stat  = irq_stat;
    next_rdata     = rdata;
    case (state)
      timer_irq_pkg::ACC_IDLE: begin
        // commands written while busy are dropped
        if (wr_acc && paddr_i == timer_irq_pkg::OFF_CMD) begin
          next_cmd_data = pwdata_i[7:0];
          next_cmd_ch   = pwdata_i[timer_irq_pkg::CMD_CH_LSB +: 3];
          next_cmd_sel  = pwdata_i[timer_irq_pkg::CMD_SEL_BIT];
          next_cmd_wr   = pwdata_i[timer_irq_pkg::CMD_WR_BIT];
          next_state    = timer_irq_pkg::ACC_ISSUE;
        end
      end
      timer_irq_pkg::ACC_ISSUE: next_state = timer_irq_pkg::ACC_WAIT;
      timer_irq_pkg::ACC_WAIT: begin
        if (link.acc_done) begin
          if (!cmd_wr) begin
            next_result = link.acc_rdata;
          end
          next_state = timer_irq_pkg::ACC_IDLE;
        end
      end
      default: next_state = timer_irq_pkg::ACC_IDLE;
    endcase
    if (wr_acc && paddr_i == timer_irq_pkg::OFF_IRQ_MASK) begin
      next_irq_mask = pwdata_i[W-1:0];
    end
    if (wr_acc && paddr_i == timer_irq_pkg::OFF_XFER_CTRL) begin
      next_xfer_en  = pwdata_i[timer_irq_pkg::XFER_EN_BIT];
      next_xfer_dis = pwdata_i[timer_irq_pkg::XFER_DIS_BIT];
    end
    if (wr_acc && paddr_i == timer_irq_pkg::OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata_i[W-1:0];
    end
    next_irq_stat = next_irq_stat | events;
    // read data is latched in the setup cycle so prdata comes from a flop
    if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        timer_irq_pkg::OFF_CMD:       next_rdata = {15'h0000, cmd_wr, 3'h0, cmd_sel,
                                                    1'b0, cmd_ch, cmd_data};
        timer_irq_pkg::OFF_RESULT:    next_rdata = {23'h000000,
                                                    state != timer_irq_pkg::ACC_IDLE, result};
        timer_irq_pkg::OFF_IRQ_STAT:  next_rdata = {26'h0000000, irq_stat};
        timer_irq_pkg::OFF_IRQ_MASK:  next_rdata = {26'h0000000, irq_mask};
        timer_irq_pkg::OFF_XFER_CTRL: next_rdata = {30'h00000000, xfer_dis, xfer_en};
        default:                      next_rdata = 32'h00000000;
      endcase
    end
  end

  // one transfer per overflow request; re-armed only after it drops
  always_comb begin
    next_dtc_start = xfer_en && link.overflow_irq[timer_irq_pkg::DTC_CH] && !dtc_wait;
    next_dtc_wait  = dtc_wait || next_dtc_start;
    if (!link.overflow_irq[timer_irq_pkg::DTC_CH] && !dtc_start) begin
      next_dtc_wait = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= timer_irq_pkg::ACC_IDLE;
      cmd_data  <= 8'h00;
      cmd_ch    <= 3'h0;
      cmd_sel   <= 1'b0;
      cmd_wr    <= 1'b0;
      result    <= 8'h00;
      irq_stat  <= 6'h00;
      irq_mask  <= 6'h00;
      any_prev  <= 5'h00;
      xfer_en   <= 1'b0;
      xfer_dis  <= 1'b0;
      dtc_start <= 1'b0;
      dtc_wait  <= 1'b0;
      rdata     <= 32'h00000000;
    end else begin
      state     <= next_state;
      cmd_data  <= next_cmd_data;
      cmd_ch    <= next_cmd_ch;
      cmd_sel   <= next_cmd_sel;
      cmd_wr    <= next_cmd_wr;
      result    <= next_result;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      any_prev  <= next_any_prev;
      xfer_en   <= next_xfer_en;
      xfer_dis  <= next_xfer_dis;
      dtc_start <= next_dtc_start;
      dtc_wait  <= next_dtc_wait;
      rdata     <= next_rdata;
    end
  end

  assign link.acc_valid               = (state == timer_irq_pkg::ACC_ISSUE);
  assign link.acc_write               = cmd_wr;
  assign link.acc_status_sel          = cmd_sel;
  assign link.acc_ch                  = cmd_ch;
  assign link.acc_wdata               = cmd_data;
  assign link.dtc_ovf_start           = dtc_start;
  assign link.transfer_disable_select = xfer_dis;
  assign prdata_o  = rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign irq_o     = |(irq_stat & irq_mask);
endmodule

// file: tb/timer_link_assertions.sv
// concurrent checks on the link between the timer block and its controller
module timer_link_assertions (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       acc_valid,
  input wire logic       acc_write,
  input wire logic       acc_status_sel,
  input wire logic [2:0] acc_ch,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata,
  input wire logic       acc_done,
  input wire logic [4:0] source_a_irq,
  input wire logic [4:0] source_b_irq,
  input wire logic [4:0] source_c_irq,
  input wire logic [4:0] overflow_irq,
  input wire logic [4:0] underflow_irq,
  input wire logic       dtc_ovf_start,
  input wire logic       transfer_disable_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence status_read;
    acc_valid && !acc_write && acc_status_sel;
  endsequence

  a_done_next: assert property (acc_valid |=> acc_done && !acc_valid)
    else $error("access not answered one cycle later");
  a_done_cause: assert property ($rose(acc_done) |-> $past(acc_valid))
    else $error("access done without a request");
  a_src_c_absent: assert property (source_c_irq[2:1] == 2'b00)
    else $error("source C request on channel 1 or 2");
  a_udf_absent: assert property ({underflow_irq[4:3], underflow_irq[0]} == 3'b000)
    else $error("underflow request on channel 0, 3 or 4");
  a_bit6_one: assert property (status_read |=> acc_rdata[6])
    else $error("status bit 6 read as 0");
  a_ch0_reserved: assert property (status_read and acc_ch == 3'h0 |=> acc_rdata[7:5] == 3'b110)
    else $error("channel 0 reserved status bits wrong");
  a_enable_c_res: assert property (acc_valid && !acc_write && !acc_status_sel
      && (acc_ch == 3'h1 || acc_ch == 3'h2) |=> !acc_rdata[2])
    else $error("reserved enable bit 2 read as 1");
  a_start_cause: assert property ($rose(dtc_ovf_start) |-> $past(overflow_irq[4]))
    else $error("transfer start without overflow request");
  a_start_clears: assert property (dtc_ovf_start && !transfer_disable_select
      |=> !overflow_irq[4])
    else $error("transfer start left overflow set");
  a_start_single: assert property (dtc_ovf_start |=> !dtc_ovf_start)
    else $error("transfer start longer than one cycle");

  c_start: cover property (dtc_ovf_start);
  c_underflow: cover property (underflow_irq != 5'h00);
  c_status_rd: cover property (acc_done && acc_status_sel);
  c_clear_wr: cover property (acc_valid && acc_write && acc_status_sel && acc_wdata == 8'hC0);
endmodule

// file: tb/testbench.sv
// self-checking bench: controller and timer block joined by the link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        rst_i;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [4:0]  ev_a, ev_b, ev_c, wrap_up, wrap_down, phase_mode, count_up;
  logic        comp_pwm;
  logic        down_zero;
  logic [31:0] rd;
  int          err_total = 0;
  int          checked = 0;
  int          cycles = 0;

  timer_link_if link();

  timer_channel_irq_status timer_channel_irq_status_i (
    .clk_i(clk_i), .rst_i(rst_i), .link(link),
    .source_a_event_i(ev_a), .source_b_event_i(ev_b), .source_c_event_i(ev_c),
    .wrap_up_i(wrap_up), .wrap_down_i(wrap_down), .phase_mode_i(phase_mode),
    .count_up_i(count_up), .comp_pwm_i(comp_pwm), .ch4_down_to_zero_i(down_zero));

  timer_irq_controller timer_irq_controller_i (
    .clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .link(link));

  timer_link_assertions timer_link_assertions_i (
    .clk_i(clk_i), .rst_i(rst_i), .acc_valid(link.acc_valid), .acc_write(link.acc_write),
    .acc_status_sel(link.acc_status_sel), .acc_ch(link.acc_ch),
    .acc_wdata(link.acc_wdata), .acc_rdata(link.acc_rdata), .acc_done(link.acc_done),
    .source_a_irq(link.source_a_irq), .source_b_irq(link.source_b_irq),
    .source_c_irq(link.source_c_irq), .overflow_irq(link.overflow_irq),
    .underflow_irq(link.underflow_irq), .dtc_ovf_start(link.dtc_ovf_start),
    .transfer_disable_select(link.transfer_disable_select));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checks made %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // irq is combinational from registers that update at the access edge
  task automatic chk_irq(input logic exp);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [2:0] ch, input logic sel, input logic wr,
                     input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    int n;
    apb(timer_irq_pkg::OFF_CMD, 1'b1, {15'h0, wr, 3'h0, sel, 1'h0, ch, d}, r);
    n = 0;
    r = 32'h00000100;
    while (r[8] !== 1'b0 && n < 20) begin
      apb(timer_irq_pkg::OFF_RESULT, 1'b0, 32'h0, r);
      n++;
    end
    chk({31'h0, r[8]}, 32'h0);
    q = r[7:0];
  endtask

  task automatic wr_reg(input logic [2:0] ch, input logic sel, input logic [7:0] d);
    logic [7:0] q;
    cmd(ch, sel, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [2:0] ch, input logic sel, input logic [7:0] exp);
    logic [7:0] q;
    cmd(ch, sel, 1'b0, 8'h00, q);
    chk({24'h0, q}, {24'h0, exp});
  endtask

  // events are single-cycle pulses; requests follow one edge later
  task automatic fire(input logic [4:0] a, b, c, up, dn, input logic dz);
    @(posedge clk_i);
    {ev_a, ev_b, ev_c, wrap_up, wrap_down, down_zero} <= {a, b, c, up, dn, dz};
    @(posedge clk_i);
    {ev_a, ev_b, ev_c, wrap_up, wrap_down, down_zero} <= '0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic tend(input string name);
    $display("test %0s finished, %0d checks so far", name, checked);
  endtask

  function automatic logic [7:0] en_all(input int ch);
    return 8'h53 | ((ch == 1 || ch == 2) ? 8'h20 : 8'h04);
  endfunction

  initial begin
    {rst_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {ev_a, ev_b, ev_c, wrap_up, wrap_down, phase_mode} = '0;
    {comp_pwm, down_zero, count_up} = {2'b00, 5'h1F};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int ch = 0; ch < 5; ch++) begin
      rd_chk(3'(ch), 1'b0, 8'h40);
      rd_chk(3'(ch), 1'b1, 8'hC0);
    end
    chk_irq(1'b0);
    tend("reset values");
    for (int ch = 0; ch < 5; ch++) begin
      wr_reg(3'(ch), 1'b0, en_all(ch) | 8'h80);
      rd_chk(3'(ch), 1'b0, en_all(ch));
    end
    tend("enable bits");
    count_up <= 5'h00;
    repeat (2) @(posedge clk_i);
    for (int ch = 0; ch < 5; ch++) rd_chk(3'(ch), 1'b1, ch == 0 ? 8'hC0 : 8'h40);
    count_up <= 5'h1F;
    tend("count direction");
    fire(5'h00, 5'h00, 5'h00, 5'h00, 5'h1F, 1'b0);
    chk({27'h0, link.underflow_irq}, 32'h0);
    @(posedge clk_i) phase_mode <= 5'h1F;
    fire(5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 1'b0);
    chk({27'h0, link.source_a_irq}, 32'h1F);
    chk({27'h0, link.source_b_irq}, 32'h1F);
    chk({27'h0, link.source_c_irq}, 32'h19);
    chk({27'h0, link.overflow_irq}, 32'h1F);
    chk({27'h0, link.underflow_irq}, 32'h06);
    tend("event requests");
    wr_reg(3'h1, 1'b0, 8'h40);
    chk({27'h0, link.source_a_irq}, 32'h1D);
    chk({27'h0, link.overflow_irq}, 32'h1D);
    chk({27'h0, link.underflow_irq}, 32'h04);
    wr_reg(3'h1, 1'b0, en_all(1));
    tend("request gating");
    rd_chk(3'h1, 1'b1, 8'hF3);
    wr_reg(3'h1, 1'b1, 8'hF3);
    rd_chk(3'h1, 1'b1, 8'hF3);
    wr_reg(3'h1, 1'b1, 8'hC0);
    rd_chk(3'h1, 1'b1, 8'hC0);
    wr_reg(3'h2, 1'b1, 8'hC0);
    rd_chk(3'h2, 1'b1, 8'hF3);
    wr_reg(3'h2, 1'b1, 8'hC0);
    chk({27'h0, link.underflow_irq}, 32'h0);
    tend("flag clearing");
    rd_chk(3'h4, 1'b1, 8'hD7);
    wr_reg(3'h4, 1'b1, 8'hC0);
    fire(5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 1'b1);
    chk({27'h0, link.overflow_irq}, 32'h09);
    @(posedge clk_i) comp_pwm <= 1'b1;
    fire(5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 1'b1);
    chk({27'h0, link.overflow_irq}, 32'h19);
    @(posedge clk_i) comp_pwm <= 1'b0;
    tend("complementary overflow");
    apb(timer_irq_pkg::OFF_XFER_CTRL, 1'b1, 32'h1, rd);
    rd_chk(3'h4, 1'b1, 8'hC0);
    apb(timer_irq_pkg::OFF_XFER_CTRL, 1'b1, 32'h3, rd);
    fire(5'h00, 5'h00, 5'h00, 5'h10, 5'h00, 1'b0);
    rd_chk(3'h4, 1'b1, 8'hD0);
    tend("transfer start");
    apb(timer_irq_pkg::OFF_IRQ_STAT, 1'b1, 32'h3F, rd);
    apb(timer_irq_pkg::OFF_IRQ_MASK, 1'b1, 32'h20, rd);
    chk_irq(1'b0);
    rd_chk(3'h0, 1'b0, en_all(0));
    chk_irq(1'b1);
    apb(timer_irq_pkg::OFF_IRQ_STAT, 1'b0, 32'h0, rd);
    chk(rd, 32'h20);
    apb(timer_irq_pkg::OFF_IRQ_MASK, 1'b1, 32'h00, rd);
    chk_irq(1'b0);
    apb(timer_irq_pkg::OFF_IRQ_MASK, 1'b1, 32'h20, rd);
    chk_irq(1'b1);
    apb(timer_irq_pkg::OFF_IRQ_STAT, 1'b1, 32'h20, rd);
    chk_irq(1'b0);
    apb(12'h020, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    tend("controller interrupt");
    give_verdict();
  end
endmodule
